// File: core/dpm_map.vh
/*
  Constants of the DLLP and power message port: register offsets,
  field positions, reset values and code values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef DPM_MAP_VH
`define DPM_MAP_VH

// Send request codes
`define DPM_REQ_NONE      2'h0
`define DPM_REQ_PM        2'h1
`define DPM_REQ_VENDOR    2'h2
`define DPM_REQ_UNUSED    2'h3

// Power message type codes
`define DPM_PM_ENTER_L1   3'h0
`define DPM_PM_ENTER_L2   3'h1
`define DPM_PM_ASPM_L1    3'h3
`define DPM_PM_REQ_ACK    3'h4

// Link DLLP type byte: power base followed by the power code, vendor
`define DPM_DLLP_PM_BASE  5'h04
`define DPM_DLLP_VENDOR   8'h30

// Register offsets (byte addresses)
`define DPM_ADDR_CTRL     4'h0
`define DPM_ADDR_STATUS   4'h4
`define DPM_ADDR_MASK     4'h8
`define DPM_ADDR_STATE    4'hc

// Control register fields
`define DPM_CTRL_ECRC_GEN 0
`define DPM_CTRL_ECRC_CHK 1
`define DPM_CTRL_RESET    2'h0

// Status and mask fields
`define DPM_EV_SENT       0
`define DPM_EV_PM_RX      1
`define DPM_EV_VENDOR_RX  2
`define DPM_EV_TLP_RX     3
`define DPM_EV_BAD_REQ    4
`define DPM_EV_WIDTH      5
`define DPM_MASK_RESET    5'h00

// State register fields
`define DPM_ST_PEND       0
`define DPM_ST_EMPTY      1
`define DPM_ST_RXTYPE_LO  4

`endif

// File: core/dpm_port.v
/*
  DLLP and power message port of the endpoint core: user send
  requests, received power and vendor DLLPs, idle status for outside
  power state logic, ECRC enables, a small register file and one
  interrupt.
  Assumes user logic, link layer and register master all run on
  core_clk_in; no input needs a synchroniser.
  Sticky status, cleared by writing ones.
  Mask of the same layout.
  One level interrupt.
  Reads answer one cycle later, no wait.
  No buffer beyond the one DLLP.
  Vendor DLLP has no valid pulse.
  Parameters pick ECRC and width.
*/
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`include "dpm_map.vh"

module dpm_port #(
  parameter       ECRC_CONFIGURED = 1,  // ECRC built in
  parameter       RETRY_CNT_W     = 8   // Retry buffer count width
) (
  input  wire                   core_clk_in,      // 100 MHz clock
  input  wire                   reset_in,         // Async, high
  // User send side
  // Request held until sent
  input  wire [1:0]             tx_req_in,        // Send request
  input  wire [2:0]             tx_pm_type_in,    // Power type
  input  wire [23:0]            tx_vendor_in,     // Vendor payload
  output wire                   tx_sent_out,      // DLLP sent pulse
  // User receive side
  // Registered, one cycle late
  output reg  [2:0]             rx_pm_type_out,   // Rx power type
  output reg  [23:0]            rx_vendor_out,    // Rx vendor data
  output reg                    rx_valid_out,     // Rx power pulse
  // Power state helpers
  // For outside link power logic
  output reg                    retry_empty_out,  // Retry empty
  output wire                   dllp_pend_out,    // DLLP pending
  output reg                    tlp_rcvd_out,     // TLP received
  output wire                   ecrc_gen_en_out,  // ECRC gen on
  output wire                   ecrc_chk_en_out,  // ECRC check on
  // Link layer side
  // Same clock as the user side
  output wire                   link_tx_valid_out, // DLLP offered
  output wire [31:0]            link_tx_data_out,  // DLLP words
  input  wire                   link_tx_ready_in,  // DLLP sent
  input  wire                   link_rx_valid_in,  // DLLP received
  input  wire [31:0]            link_rx_data_in,   // Rx DLLP words
  input  wire                   link_rx_tlp_in,    // TLP received
  input  wire [RETRY_CNT_W-1:0] retry_count_in,    // Retry entries
  // Register port
  // Plain strobes, no wait
  input  wire [3:0]             reg_addr_in,      // Byte address
  input  wire [31:0]            reg_wdata_in,     // Write data
  input  wire                   reg_wr_in,        // Write strobe
  input  wire                   reg_rd_in,        // Read strobe
  output reg  [31:0]            reg_rdata_out,    // Read data
  // Interrupt
  // High while unmasked bit set
  output wire                   irq_out           // Level interrupt
);

  ////////////////////////////////////////////////////////////////////
  // Declarations
  // Each register-file and held rx flop has a _next twin
  // Power code check is repeated in the sequencer
  localparam EVW = `DPM_EV_WIDTH;       // Event count

  reg  [1:0]     ctrl_reg;              // ECRC enable bits
  reg  [1:0]     ctrl_next;             // Next control
  reg  [EVW-1:0] status_reg;            // Sticky events
  reg  [EVW-1:0] status_next;           // Next sticky events
  reg  [EVW-1:0] mask_reg;              // Interrupt mask
  reg  [EVW-1:0] mask_next;             // Next mask
  reg  [31:0]    rdata_next;            // Next read data
  reg  [2:0]     rx_type_next;          // Next rx power type
  reg  [23:0]    rx_vendor_next;        // Next rx vendor data
  reg            rx_pm_hit;             // Power DLLP seen
  reg            rx_vendor_hit;         // Vendor DLLP seen
  wire [EVW-1:0] events;                // This cycle's events
  wire           seq_sent;              // Sent pulse
  wire           seq_bad;               // Illegal request pulse
  wire           seq_pend;              // DLLP pending
  reg            vendor_evt_reg;        // Vendor arrival pulse

  // Legal power code check
  // Same test as in the sequencer
  // Undefined codes count as unknown
  function pm_legal;
    input [2:0] code;
    begin
      pm_legal = (code == `DPM_PM_ENTER_L1) ||
                 (code == `DPM_PM_ENTER_L2) ||
                 (code == `DPM_PM_ASPM_L1) ||
                 (code == `DPM_PM_REQ_ACK);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Transmit sequencer
  // Offers one DLLP to the link
  // Holds it until the link takes it
  // Pulses sent one cycle after the take
  // Waits for request none before rearming
  // Undefined codes only pulse illegal
  dpm_tx_seq u_tx_seq (
    .core_clk_in    (core_clk_in),
    .reset_in       (reset_in),
    .req_in         (tx_req_in),
    .pm_type_in     (tx_pm_type_in),
    .vendor_in      (tx_vendor_in),
    .link_ready_in  (link_tx_ready_in),
    .link_valid_out (link_tx_valid_out),
    .link_data_out  (link_tx_data_out),
    .pend_out       (seq_pend),
    .sent_out       (seq_sent),
    .bad_req_out    (seq_bad)
  );

  // Sent straight from a sequencer flop, pending decoded from its state
  assign tx_sent_out   = seq_sent;
  assign dllp_pend_out = seq_pend;

  ////////////////////////////////////////////////////////////////////
  // ECRC enables, forced low when not configured in
  // Enables set by software in control
  // Option left out: flags stay low
  // Control bits still read as written
  // User reserves CRC room while gen on
  assign ecrc_gen_en_out = (ECRC_CONFIGURED != 0) &&
                           ctrl_reg[`DPM_CTRL_ECRC_GEN];
  assign ecrc_chk_en_out = (ECRC_CONFIGURED != 0) &&
                           ctrl_reg[`DPM_CTRL_ECRC_CHK];

  ////////////////////////////////////////////////////////////////////
  // Received DLLP decode
  // Type byte picks power or vendor
  // Power also needs a defined code
  // Unknown DLLPs dropped silently
  // Held type and payload untouched
  // Vendor never raises power valid
  always @* begin
    rx_pm_hit      = 1'b0;
    rx_vendor_hit  = 1'b0;
    rx_type_next   = rx_pm_type_out;
    rx_vendor_next = rx_vendor_out;
    if (link_rx_valid_in) begin
      // Power DLLP with a known code
      if (link_rx_data_in[31:27] == `DPM_DLLP_PM_BASE &&
          pm_legal(link_rx_data_in[26:24])) begin
        rx_pm_hit    = 1'b1;
        rx_type_next = link_rx_data_in[26:24];
      end else if (link_rx_data_in[31:24] == `DPM_DLLP_VENDOR) begin
        // Vendor DLLP payload
        rx_vendor_hit  = 1'b1;
        rx_vendor_next = link_rx_data_in[23:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receive outputs and idle helpers
  // One cycle behind the link inputs
  // Type and payload hold until next
  // Valid and TLP pulses last one cycle
  // Retry empty high out of reset
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_pm_type_out  <= 3'h0;
      rx_vendor_out   <= 24'h000000;
      rx_valid_out    <= 1'b0;
      vendor_evt_reg  <= 1'b0;
      retry_empty_out <= 1'b1;
      tlp_rcvd_out    <= 1'b0;
    end else begin
      rx_pm_type_out  <= rx_type_next;
      rx_vendor_out   <= rx_vendor_next;
      rx_valid_out    <= rx_pm_hit;
      vendor_evt_reg  <= rx_vendor_hit;
      retry_empty_out <= (retry_count_in == {RETRY_CNT_W{1'b0}});
      tlp_rcvd_out    <= link_rx_tlp_in;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Event vector, aligned with the output pulses
  // One bit per event
  // Status sets the cycle after a pulse
  // Sent uses the pulse itself
  // Vendor arrival has its own flop
  assign events[`DPM_EV_SENT]      = seq_sent;
  assign events[`DPM_EV_PM_RX]     = rx_valid_out;
  assign events[`DPM_EV_VENDOR_RX] = vendor_evt_reg;
  assign events[`DPM_EV_TLP_RX]    = tlp_rcvd_out;
  assign events[`DPM_EV_BAD_REQ]   = seq_bad;

  // Level, from flops only
  // Drops once bit cleared or masked
  assign irq_out = |(status_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////
  // Register writes; a new event wins over its clear
  // Control and mask take the value
  // Status: write ones to clear
  // Same-cycle event sets bit again
  // So software never loses an event
  // Other offsets ignored
  always @* begin
    ctrl_next   = ctrl_reg;
    mask_next   = mask_reg;
    status_next = status_reg | events;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `DPM_ADDR_CTRL: begin
          ctrl_next = reg_wdata_in[1:0];
        end
        `DPM_ADDR_STATUS: begin
          // Set wins over clear
          status_next = (status_reg & ~reg_wdata_in[EVW-1:0]) | events;
        end
        `DPM_ADDR_MASK: begin
          mask_next = reg_wdata_in[EVW-1:0];
        end
        default: begin
          ctrl_next = ctrl_reg;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register reads; unmapped addresses read zero
  // Loaded on the strobe only
  // Stands one cycle, then zero
  // No wait, no side effect
  // Status survives a read
  // State: pending, empty, last type
  always @* begin
    rdata_next = 32'h00000000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `DPM_ADDR_CTRL: begin
          rdata_next = {30'h00000000, ctrl_reg};
        end
        `DPM_ADDR_STATUS: begin
          rdata_next = {27'h0000000, status_reg};
        end
        `DPM_ADDR_MASK: begin
          rdata_next = {27'h0000000, mask_reg};
        end
        `DPM_ADDR_STATE: begin
          // Bits 6:4 type, 1 empty, 0 pend
          rdata_next = {25'h0000000, rx_pm_type_out, 2'h0,
                        retry_empty_out, seq_pend};
        end
        default: begin
          rdata_next = 32'h00000000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register file flops
  // All clear on reset
  // Interrupt low until unmasked
  // Read data zero when idle
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_reg      <= `DPM_CTRL_RESET;
      status_reg    <= {EVW{1'b0}};
      mask_reg      <= `DPM_MASK_RESET;
      reg_rdata_out <= 32'h00000000;
    end else begin
      ctrl_reg      <= ctrl_next;
      status_reg    <= status_next;
      mask_reg      <= mask_next;
      reg_rdata_out <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Limits
  // No synchroniser: one clock for all
  // One DLLP in flight at a time
  // New request waits for release
  // Back-to-back rx DLLPs both seen
  // Unknown request codes never sent
  // Illegal request only flagged

endmodule

// File: core/dpm_tx_seq.v
/*
  Transmit sequencer of the DLLP port: takes a user send request,
  hands one DLLP to the link transmitter and reports when it went out.
  Assumes the requester and the link transmitter share core_clk_in.
*/
`timescale 1ns/1ns
`include "dpm_map.vh"

module dpm_tx_seq (
  input  wire        core_clk_in,       // System clock
  input  wire        reset_in,          // Async reset, active high
  input  wire [1:0]  req_in,            // Send request code
  input  wire [2:0]  pm_type_in,        // Power message type
  input  wire [23:0] vendor_in,         // Vendor payload
  input  wire        link_ready_in,     // Link took the DLLP
  output wire        link_valid_out,    // DLLP offered to link
  output wire [31:0] link_data_out,     // Type byte and payload
  output wire        pend_out,          // DLLP waiting to go
  output reg         sent_out,          // One-cycle sent pulse
  output reg         bad_req_out        // Illegal request pulse
);

  ////////////////////////////////////////////////////////////////////
  // States
  localparam [1:0] ST_IDLE = 2'h0;      // Waiting for a request
  localparam [1:0] ST_SEND = 2'h1;      // DLLP offered to link
  localparam [1:0] ST_DROP = 2'h2;      // Sent, wait for release

  reg [1:0]  state_reg;                 // Current state
  reg [1:0]  state_next;                // Next state
  reg [31:0] dllp_reg;                  // Latched DLLP
  reg [31:0] dllp_next;                 // Next latched DLLP

  // Legal power code check
  function pm_legal;
    input [2:0] code;
    begin
      pm_legal = (code == `DPM_PM_ENTER_L1) ||
                 (code == `DPM_PM_ENTER_L2) ||
                 (code == `DPM_PM_ASPM_L1) ||
                 (code == `DPM_PM_REQ_ACK);
    end
  endfunction

  assign link_valid_out = (state_reg == ST_SEND);
  assign link_data_out  = dllp_reg;
  assign pend_out       = (state_reg == ST_SEND);

  ////////////////////////////////////////////////////////////////////
  // Next state and DLLP build
  always @* begin
    state_next = state_reg;
    dllp_next  = dllp_reg;
    case (state_reg)
      ST_IDLE: begin
        // Decode request code
        if (req_in == `DPM_REQ_PM && pm_legal(pm_type_in)) begin
          dllp_next  = {`DPM_DLLP_PM_BASE, pm_type_in, 24'h000000};
          state_next = ST_SEND;
        end else if (req_in == `DPM_REQ_VENDOR) begin
          dllp_next  = {`DPM_DLLP_VENDOR, vendor_in};
          state_next = ST_SEND;
        end
      end
      ST_SEND: begin
        // Leave once the link has transmitted it
        if (link_ready_in) begin
          state_next = ST_DROP;
        end
      end
      ST_DROP: begin
        // Held request must not send twice
        if (req_in == `DPM_REQ_NONE) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // State, sent pulse and illegal request pulse
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg   <= ST_IDLE;
      dllp_reg    <= 32'h00000000;
      sent_out    <= 1'b0;
      bad_req_out <= 1'b0;
    end else begin
      state_reg   <= state_next;
      dllp_reg    <= dllp_next;
      sent_out    <= (state_reg == ST_SEND) && link_ready_in;
      bad_req_out <= (state_reg == ST_IDLE) &&
                     ((req_in == `DPM_REQ_UNUSED) ||
                      (req_in == `DPM_REQ_PM && !pm_legal(pm_type_in)));
    end
  end

endmodule

// File: sim/dpm_port_chk.sv
/*
  Checker for the DLLP port: send handshake, received DLLPs, idle
  helpers and ECRC enables, seen only at the top module's ports.
  Assumes one clock domain and a bind onto every port instance.
*/
`timescale 1ns/1ns
module dpm_port_chk #(
  parameter ECRC_CONFIGURED = 1,
  parameter RETRY_CNT_W     = 8
) (
  input wire logic                   core_clk_in,
  input wire logic                   reset_in,
  input wire logic [1:0]             tx_req_in,
  input wire logic [2:0]             tx_pm_type_in,
  input wire logic [23:0]            tx_vendor_in,
  input wire logic                   tx_sent_out,
  input wire logic [2:0]             rx_pm_type_out,
  input wire logic [23:0]            rx_vendor_out,
  input wire logic                   rx_valid_out,
  input wire logic                   retry_empty_out,
  input wire logic                   dllp_pend_out,
  input wire logic                   tlp_rcvd_out,
  input wire logic                   ecrc_gen_en_out,
  input wire logic                   ecrc_chk_en_out,
  input wire logic                   link_tx_valid_out,
  input wire logic [31:0]            link_tx_data_out,
  input wire logic                   link_tx_ready_in,
  input wire logic                   link_rx_valid_in,
  input wire logic [31:0]            link_rx_data_in,
  input wire logic                   link_rx_tlp_in,
  input wire logic [RETRY_CNT_W-1:0] retry_count_in,
  input wire logic [3:0]             reg_addr_in,
  input wire logic [31:0]            reg_wdata_in,
  input wire logic                   reg_wr_in
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////////////
  // Decoded views of the inputs
  wire [2:0]  rx_code = link_rx_data_in[26:24];  // Power code field
  wire [23:0] rx_pay  = link_rx_data_in[23:0];   // Vendor payload
  wire [1:0]  wd_lo   = reg_wdata_in[1:0];       // Enable bits
  wire        took    = link_tx_valid_out && link_tx_ready_in;
  wire        held    = link_tx_valid_out && !link_tx_ready_in;
  wire        ctrl_wr = reg_wr_in && reg_addr_in == 4'h0;
  wire        vd_ok   = link_rx_valid_in && link_rx_data_in[31:24] == 8'h30;
  wire        pm_ok   = link_rx_valid_in && link_rx_data_in[31:27] == 5'h04
                        && (rx_code inside {3'h0, 3'h1, 3'h3, 3'h4});
  ////////////////////////////////////////////////////////////////////////
  // Assertions
  sent_after_a: assert property (took |=> tx_sent_out)
    else $error("sent pulse missing");
  sent_cause_a: assert property (tx_sent_out |-> $past(took))
    else $error("sent pulse without link take");
  offer_held_a: assert property (held
    |=> link_tx_valid_out && $stable(link_tx_data_out))
    else $error("offered DLLP dropped or changed");
  pend_flag_a: assert property (dllp_pend_out == link_tx_valid_out)
    else $error("pending flag wrong");
  tx_word_a: assert property (
    $rose(link_tx_valid_out)
    |-> link_tx_data_out == ($past(tx_req_in) == 2'h2 ?
    {8'h30, $past(tx_vendor_in)} : {5'h04, $past(tx_pm_type_in), 24'h0}))
    else $error("transmitted DLLP word wrong");
  empty_flag_a: assert property (1'b1
    |=> retry_empty_out == ($past(retry_count_in) == 0))
    else $error("retry empty flag wrong");
  tlp_seen_a: assert property (link_rx_tlp_in |=> tlp_rcvd_out)
    else $error("TLP received pulse missing");
  rx_power_a: assert property (pm_ok
    |=> rx_valid_out && rx_pm_type_out == $past(rx_code))
    else $error("received power DLLP not reported");
  rx_cause_a: assert property (rx_valid_out |-> $past(pm_ok))
    else $error("receive valid without power DLLP");
  rx_vendor_a: assert property (vd_ok
    |=> rx_vendor_out == $past(rx_pay))
    else $error("vendor payload not reported");
  ecrc_flag_a: assert property (ctrl_wr
    |=> {ecrc_chk_en_out, ecrc_gen_en_out}
    == ($past(wd_lo) & {2{ECRC_CONFIGURED != 0}}))
    else $error("ECRC enable flags wrong");
  ////////////////////////////////////////////////////////////////////////
  // Main scenarios reached
  vendor_c: cover property ($rose(link_tx_valid_out) && tx_req_in == 2'h2);
  power_rx_c: cover property (pm_ok);
  tlp_c: cover property (link_rx_tlp_in);
endmodule
bind dpm_port dpm_port_chk #(.ECRC_CONFIGURED(ECRC_CONFIGURED),
  .RETRY_CNT_W(RETRY_CNT_W)) u_dpm_port_chk (.*);

// File: sim/dpm_user_model.sv
/*
  User-side requester model: presents a send request with its power
  code or vendor payload and holds it until the sent pulse.
  Assumes it shares the port's clock and reset.
*/
`timescale 1ns/1ns
module dpm_user_model (
  input  wire logic        clk_in,    // Shared clock
  input  wire logic        reset_in,  // Async, high
  input  wire logic        go_in,     // Load a new request
  input  wire logic [1:0]  kind_in,   // Request code to present
  input  wire logic [2:0]  pm_in,     // Power code to present
  input  wire logic [23:0] pay_in,    // Payload to present
  input  wire logic        sent_in,   // Sent pulse from the port
  input  wire logic        ecrc_gen_in, // Generation enable
  output logic      [1:0]  req_out = 2'h0,
  output logic      [2:0]  pm_out  = 3'h0,
  output logic      [23:0] pay_out = 24'h0,
  output logic             td_out     // TD bit of sent TLPs
);
  // TD set in every TLP header while generation is on
  assign td_out = ecrc_gen_in;
  ////////////////////////////////////////////////////////////////////////
  // Request register: load on go, back to none once sent
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      req_out <= 2'h0;
    end else if (go_in) begin
      req_out <= kind_in;
      pm_out  <= pm_in;
      pay_out <= pay_in;
    end else if (sent_in) begin
      req_out <= 2'h0;
    end
  end
endmodule

// File: sim/tb_dpm_port.sv
/*
  Testbench of the DLLP port: send, refuse, receive, idle helpers,
  ECRC enables, registers and interrupt.
  Assumes the checker is bound and the requester model is compiled.
*/
`timescale 1ns/1ns
`define CHK(n,e,a) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_dpm_port;
  logic        clk = 0, reset_in = 1, go = 0, link_rx_tlp_in = 0;
  logic        tx_sent_out, rx_valid_out, retry_empty_out, dllp_pend_out;
  logic        tlp_rcvd_out, ecrc_gen_en_out, ecrc_chk_en_out, irq_out;
  logic        link_tx_valid_out, link_tx_ready_in = 0;
  logic        link_rx_valid_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  logic [1:0]  tx_req_in, kind = 0;
  logic [2:0]  tx_pm_type_in, pmc = 0, rx_pm_type_out;
  logic [23:0] tx_vendor_in, pay = 0, rx_vendor_out;
  logic [31:0] link_tx_data_out, link_rx_data_in = 0, reg_wdata_in = 0;
  logic [31:0] reg_rdata_out, d;
  logic        td;
  logic [7:0]  retry_count_in = 0;
  logic [3:0]  reg_addr_in = 0;
  logic [2:0]  codes [0:3] = '{3'h0, 3'h1, 3'h3, 3'h4};
  int          n_mismatch = 0, tests_run = 0;
  always #5 clk = ~clk;
  dpm_port u_dpm_port (.core_clk_in(clk), .*);
  dpm_user_model u_dpm_user_model (.clk_in(clk), .reset_in(reset_in),
    .go_in(go), .kind_in(kind), .pm_in(pmc), .pay_in(pay),
    .sent_in(tx_sent_out), .req_out(tx_req_in), .pm_out(tx_pm_type_in),
    .pay_out(tx_vendor_in), .ecrc_gen_in(ecrc_gen_en_out), .td_out(td));
  ////////////////////////////////////////////////////////////////////////
  // Register bus and stimulus helpers
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk); reg_addr_in <= a; reg_wdata_in <= v; reg_wr_in <= 1;
    @(posedge clk); reg_wr_in <= 0; #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk); reg_addr_in <= a; reg_rd_in <= 1;
    @(posedge clk); reg_rd_in <= 0; #1 v = reg_rdata_out;
  endtask
  task automatic launch(input logic [1:0] k, input logic [2:0] c,
                        input logic [23:0] p);
    @(posedge clk); go <= 1; kind <= k; pmc <= c; pay <= p;
    @(posedge clk); go <= 0;
  endtask
  task automatic rx(input logic [31:0] v);
    @(posedge clk); link_rx_valid_in <= 1; link_rx_data_in <= v;
    @(posedge clk); link_rx_valid_in <= 0; #1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // One send with link latency lat, judged at every step
  task automatic send(input logic [1:0] k, input logic [2:0] c,
                      input logic [23:0] p, input int lat);
    int i;
    logic [31:0] x;
    x = (k == 2'h2) ? {8'h30, p} : {5'h04, c, 24'h0};
    @(posedge clk); link_tx_ready_in <= (lat == 0);
    launch(k, c, p);
    i = 0;
    do begin @(posedge clk); #1; i++; end
      while (link_tx_valid_out !== 1'b1 && i < 8);
    if (i == 8) begin n_mismatch++; conclude; end
    `CHK("link word", x, link_tx_data_out)
    `CHK("pending", 1'b1, dllp_pend_out)
    if (lat != 0) begin
      repeat (lat) @(posedge clk);
      link_tx_ready_in <= 1;
    end
    @(posedge clk); link_tx_ready_in <= 0; #1;
    `CHK("sent", 1'b1, tx_sent_out)
    `CHK("pending off", 1'b0, dllp_pend_out)
    @(posedge clk); #1;
    `CHK("sent once", 1'b0, tx_sent_out)
  endtask
  task automatic t_send;
    for (int i = 0; i < 4; i++) send(2'h1, codes[i], 24'h0, (i % 2) * 2);
    send(2'h2, 3'h0, 24'ha5c3e1, 3);
    rd(4'h4, d);
    `CHK("sent status", 1'b1, d[0])
    wr(4'h4, 32'h1f);
  endtask
  task automatic t_bad;
    for (int j = 0; j < 2; j++) begin
      wr(4'h4, 32'h1f);
      launch(j ? 2'h1 : 2'h3, 3'h5, 24'h0);
      repeat (3) @(posedge clk); #1;
      `CHK("refused", 1'b0, link_tx_valid_out)
      rd(4'h4, d);
      `CHK("refused status", 1'b1, d[4])
      launch(2'h0, 3'h0, 24'h0);
    end
  endtask
  task automatic t_rx;
    for (int i = 0; i < 4; i++) begin
      rx({5'h04, codes[i], 24'h0});
      `CHK("rx valid", 1'b1, rx_valid_out)
      `CHK("rx type", codes[i], rx_pm_type_out)
    end
    rx({8'h30, 24'h5a0f3c});
    `CHK("rx payload", 24'h5a0f3c, rx_vendor_out)
    `CHK("vendor no valid", 1'b0, rx_valid_out)
    rx(32'h55123456);
    `CHK("ignored payload", 24'h5a0f3c, rx_vendor_out)
    `CHK("ignored type", 3'h4, rx_pm_type_out)
    rd(4'hc, d);
    `CHK("state read", 32'h42, d)
    rd(4'h4, d);
    `CHK("rx status", 2'h3, d[2:1])
  endtask
  task automatic t_idle;
    @(posedge clk); retry_count_in <= 8'h05;
    @(posedge clk); #1;
    `CHK("retry busy", 1'b0, retry_empty_out)
    @(posedge clk); retry_count_in <= 8'h00;
    @(posedge clk); #1;
    `CHK("retry empty", 1'b1, retry_empty_out)
    @(posedge clk); link_rx_tlp_in <= 1;
    @(posedge clk); link_rx_tlp_in <= 0; #1;
    `CHK("tlp pulse", 1'b1, tlp_rcvd_out)
    @(posedge clk); #1;
    `CHK("tlp pulse end", 1'b0, tlp_rcvd_out)
  endtask
  task automatic t_ecrc;
    for (int v = 3; v >= 0; v--) begin
      wr(4'h0, v);
      `CHK("ecrc gen", v[0], ecrc_gen_en_out)
      `CHK("ecrc chk", v[1], ecrc_chk_en_out)
      `CHK("td bit", v[0], td)
      rd(4'h0, d);
      `CHK("ctrl read", v[1:0], d[1:0])
    end
  endtask
  task automatic t_irq;
    wr(4'h4, 32'h1f);
    wr(4'h8, 32'h0);
    t_idle;
    `CHK("irq masked", 1'b0, irq_out)
    wr(4'h8, 32'h8);
    `CHK("irq raised", 1'b1, irq_out)
    wr(4'h4, 32'h8);
    `CHK("irq cleared", 1'b0, irq_out)
    rd(4'h2, d);
    `CHK("unmapped read", 32'h0, d)
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic conclude;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    `CHK("reset empty", 1'b1, retry_empty_out)
    `CHK("reset sent", 1'b0, tx_sent_out)
    reset_in <= 0;
    rd(4'h8, d);
    `CHK("mask reset", 32'h0, d)
    t_send;
    t_bad;
    t_rx;
    t_ecrc;
    t_irq;
    conclude;
  end
endmodule
